/* rsd_alu.sv */
// Execution datapath: rotate, subtract with borrow, decrement and skip
//
// Behaviour
// RULE_01 - Rotate right through carry into accumulator
// RULE_02 - Memory subtract with borrow into accumulator
// RULE_03 - Immediate subtract with borrow into accumulator
// RULE_04 - Subtract with borrow written to memory
// RULE_05 - Carry clear on negative, set otherwise
// RULE_06 - Subtracts update six flags; rotate carry
// RULE_07 - Decrement memory, skip next if zero
// RULE_08 - Decrement into accumulator, skip if zero
// RULE_09 - Skip inserts one dummy cycle
// RULE_10 - Nonzero result continues without dummy cycle
// RULE_11 - Immediate form uses instruction field only
`default_nettype none
module rsd_alu
  import rsd_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic op_valid,
  input wire rsd_op_t op_sel,
  input wire logic [7:0] mem_rdata,
  input wire logic [7:0] imm_data,
  output logic op_ready,
  output logic [7:0] acc_q,
  output logic [5:0] flags_q,
  output logic mem_we_q,
  output logic [7:0] mem_wdata_q,
  output logic skip_q,
  output logic dummy_cycle_q
);

  // ==========================================================
  // Subtract with borrow helper: {flags, result}
  function automatic logic [13:0] sub_borrow(
    input logic [7:0] a,
    input logic [7:0] b,
    input logic c,
    input logic z_old
  );
    logic [8:0] full;
    logic [4:0] low;
    logic [7:0] r;
    logic [5:0] f;
    full = {1'b0, a} - {1'b0, b} - {8'h00, ~c};
    low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ~c};
    r = full[7:0];
    f = '0;
    // RULE_05 carry from borrow
    f[RSD_FLAG_CARRY] = ~full[8];
    f[RSD_FLAG_AUX] = ~low[4];
    f[RSD_FLAG_ZERO] = (r == 8'h00);
    f[RSD_FLAG_RANGE] = (a[7] ^ b[7]) & (a[7] ^ r[7]);
    f[RSD_FLAG_SIGNED_CARRY] = r[7] ^ f[RSD_FLAG_RANGE];
    f[RSD_FLAG_CHAINED_ZERO] = (r == 8'h00) & z_old;
    sub_borrow = {f, r};
  endfunction : sub_borrow

  logic [13:0] sub_mem;
  logic [13:0] sub_imm;
  logic [7:0] dec_val;
  logic dec_zero;
  logic is_dec;

  // RULE_02 memory operand subtract
  assign sub_mem = sub_borrow(acc_q, mem_rdata, flags_q[RSD_FLAG_CARRY],
                              flags_q[RSD_FLAG_CHAINED_ZERO]);
  // RULE_11 immediate field as subtrahend
  assign sub_imm = sub_borrow(acc_q, imm_data, flags_q[RSD_FLAG_CARRY],
                              flags_q[RSD_FLAG_CHAINED_ZERO]);
  assign dec_val = mem_rdata - 8'h01;
  assign dec_zero = (dec_val == 8'h00);
  assign is_dec = (op_sel == RSD_OP_DECREMENT_SKIP_IF_ZERO) ||
                  (op_sel == RSD_OP_DECREMENT_COPY_SKIP_IF_ZERO);
  assign op_ready = ~dummy_cycle_q;

  // ==========================================================
  // Accumulator
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      acc_q <= RSD_ACC_RST;
    else if (op_valid && op_ready)
    begin
      unique case (op_sel)
        // RULE_01 rotate into accumulator
        RSD_OP_ROTATE_RIGHT_THROUGH_CARRY_TO_ACC:
          acc_q <= {flags_q[RSD_FLAG_CARRY], mem_rdata[7:1]};
        RSD_OP_SUBTRACT_WITH_BORROW_ACC:
          acc_q <= sub_mem[7:0];
        // RULE_03 immediate result to accumulator
        RSD_OP_SUBTRACT_WITH_BORROW_IMM:
          acc_q <= sub_imm[7:0];
        // RULE_08 decremented copy
        RSD_OP_DECREMENT_COPY_SKIP_IF_ZERO:
          acc_q <= dec_val;
        default:
          acc_q <= acc_q;
      endcase
    end
  end

  // ==========================================================
  // Status flags
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      flags_q <= RSD_FLAGS_RST;
    else if (op_valid && op_ready)
    begin
      unique case (op_sel)
        // RULE_06 rotate touches carry only
        RSD_OP_ROTATE_RIGHT_THROUGH_CARRY_TO_ACC:
          flags_q[RSD_FLAG_CARRY] <= mem_rdata[0];
        // RULE_06 all six flags on subtract
        RSD_OP_SUBTRACT_WITH_BORROW_ACC,
        RSD_OP_SUBTRACT_WITH_BORROW_TO_MEM:
          flags_q <= sub_mem[13:8];
        RSD_OP_SUBTRACT_WITH_BORROW_IMM:
          flags_q <= sub_imm[13:8];
        default:
          flags_q <= flags_q;
      endcase
    end
  end

  // ==========================================================
  // Memory write-back
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      mem_we_q <= 1'b0;
      mem_wdata_q <= 8'h00;
    end
    else
    begin
      mem_we_q <= 1'b0;
      if (op_valid && op_ready)
      begin
        // RULE_04 result to memory
        if (op_sel == RSD_OP_SUBTRACT_WITH_BORROW_TO_MEM)
        begin
          mem_we_q <= 1'b1;
          mem_wdata_q <= sub_mem[7:0];
        end
        // RULE_07 decrement stored back
        else if (op_sel == RSD_OP_DECREMENT_SKIP_IF_ZERO)
        begin
          mem_we_q <= 1'b1;
          mem_wdata_q <= dec_val;
        end
      end
    end
  end

  // ==========================================================
  // Skip and dummy cycle
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      skip_q <= 1'b0;
      dummy_cycle_q <= 1'b0;
    end
    else
    begin
      // RULE_09 one dummy cycle after skip
      dummy_cycle_q <= skip_q;
      // RULE_10 no skip when nonzero
      skip_q <= op_valid && op_ready && is_dec && dec_zero;
    end
  end

endmodule : rsd_alu
`default_nettype wire

/* rsd_alu_chk.sv */
// Assertions on the ALU ports
`default_nettype none
module rsd_alu_chk
  import rsd_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic op_valid,
  input wire rsd_op_t op_sel,
  input wire logic [7:0] mem_rdata,
  input wire logic [7:0] imm_data,
  input wire logic op_ready,
  input wire logic [7:0] acc_q,
  input wire logic [5:0] flags_q,
  input wire logic mem_we_q,
  input wire logic [7:0] mem_wdata_q,
  input wire logic skip_q,
  input wire logic dummy_cycle_q
);
  logic [8:0] dm, di;
  rsd_op_t op;
  assign dm = {1'h0, acc_q} - {1'h0, mem_rdata} - {8'h00, ~flags_q[0]};
  assign di = {1'h0, acc_q} - {1'h0, imm_data} - {8'h00, ~flags_q[0]};
  assign op = (op_valid && op_ready) ? op_sel : RSD_OP_NONE;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  AST_ROT: assert property (op == RSD_OP_ROTATE_RIGHT_THROUGH_CARRY_TO_ACC
    |=> acc_q == {$past(flags_q[0]), $past(mem_rdata[7:1])} && !mem_we_q
    && flags_q[0] == $past(mem_rdata[0]) && $stable(flags_q[5:1]))
    else $error("rotate wrong");
  AST_SUB_ACC: assert property (op == RSD_OP_SUBTRACT_WITH_BORROW_ACC
    |=> acc_q == $past(dm[7:0]) && flags_q[0] == !$past(dm[8]))
    else $error("subtract wrong");
  AST_SUB_IMM: assert property (op == RSD_OP_SUBTRACT_WITH_BORROW_IMM
    |=> acc_q == $past(di[7:0]) && flags_q[0] == !$past(di[8]))
    else $error("immediate subtract wrong");
  AST_SUB_MEM: assert property (op == RSD_OP_SUBTRACT_WITH_BORROW_TO_MEM
    |=> mem_we_q && mem_wdata_q == $past(dm[7:0]) && $stable(acc_q))
    else $error("memory subtract wrong");
  AST_DEC: assert property (op == RSD_OP_DECREMENT_SKIP_IF_ZERO
    |=> mem_we_q && mem_wdata_q == $past(mem_rdata) - 8'h01
    && skip_q == ($past(mem_rdata) == 8'h01)) else $error("decrement wrong");
  AST_COPY: assert property (op == RSD_OP_DECREMENT_COPY_SKIP_IF_ZERO
    |=> acc_q == $past(mem_rdata) - 8'h01 && !mem_we_q && $stable(flags_q)
    && skip_q == ($past(mem_rdata) == 8'h01)) else $error("copy wrong");
  AST_DUMMY: assert property (skip_q |=> dummy_cycle_q && !op_ready)
    else $error("dummy cycle missing");
  AST_NODUMMY: assert property (!skip_q |=> !dummy_cycle_q)
    else $error("dummy cycle unexpected");
endmodule : rsd_alu_chk
bind rsd_alu rsd_alu_chk u_chk (.clk, .reset, .op_valid, .op_sel, .mem_rdata,
  .imm_data, .op_ready, .acc_q, .flags_q, .mem_we_q, .mem_wdata_q, .skip_q,
  .dummy_cycle_q);
`default_nettype wire

/* rsd_mem_model.sv */
// Data memory byte model facing the ALU
`default_nettype none
module rsd_mem_model (
  input wire logic clk,
  input wire logic we,
  input wire logic [7:0] wdata,
  input wire logic ld,
  input wire logic [7:0] ld_val,
  output logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clk)
  begin
    if (we) rdata <= wdata;
    else if (ld) rdata <= ld_val;
  end
endmodule : rsd_mem_model
`default_nettype wire

/* rsd_pkg.sv */
// Package: operation codes, flag layout and reset values for the ALU
`default_nettype none
package rsd_pkg;
  // ==========================================================
  // Operation select
  typedef enum logic [2:0]
  {
    RSD_OP_NONE,
    RSD_OP_ROTATE_RIGHT_THROUGH_CARRY_TO_ACC,
    RSD_OP_SUBTRACT_WITH_BORROW_ACC,
    RSD_OP_SUBTRACT_WITH_BORROW_IMM,
    RSD_OP_SUBTRACT_WITH_BORROW_TO_MEM,
    RSD_OP_DECREMENT_SKIP_IF_ZERO,
    RSD_OP_DECREMENT_COPY_SKIP_IF_ZERO
  } rsd_op_t;
  // ==========================================================
  // Status bit positions in the flags vector
  localparam int RSD_FLAG_CARRY = 0;
  localparam int RSD_FLAG_AUX = 1;
  localparam int RSD_FLAG_ZERO = 2;
  localparam int RSD_FLAG_RANGE = 3;
  localparam int RSD_FLAG_SIGNED_CARRY = 4;
  localparam int RSD_FLAG_CHAINED_ZERO = 5;
  localparam int RSD_FLAG_W = 6;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RSD_ACC_RST = 8'h00;
  localparam logic [5:0] RSD_FLAGS_RST = 6'h00;
endpackage : rsd_pkg
`default_nettype wire

/* tb.sv */
// Self-checking bench for the ALU
`default_nettype none
module tb;
  import rsd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, reset = 1'h1, op_valid = 1'h0, ld = 1'h1;
  rsd_op_t op_sel = RSD_OP_NONE;
  logic [7:0] mem_rdata, imm_data = 8'h00, ld_val = 8'h00, acc_q, mem_wdata_q;
  logic op_ready, mem_we_q, skip_q, dummy_cycle_q;
  logic [5:0] flags_q;
  int error_cnt = 0, comparisons = 0;
  always #4 clk = ~clk;
  rsd_alu uut (.clk, .reset, .op_valid, .op_sel, .mem_rdata, .imm_data,
    .op_ready, .acc_q, .flags_q, .mem_we_q, .mem_wdata_q, .skip_q,
    .dummy_cycle_q);
  rsd_mem_model mem (.clk, .we(mem_we_q), .wdata(mem_wdata_q), .ld, .ld_val,
    .rdata(mem_rdata));
  task automatic close_out();
    if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    comparisons++;
    if (s !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic run(rsd_op_t s, logic [7:0] m, i, ea, ef, em, sk);
    int k;
    @(negedge clk);
    ld = 1'h1;
    ld_val = m;
    @(negedge clk);
    ld = 1'h0;
    op_valid = 1'h1;
    op_sel = s;
    imm_data = i;
    for (k = 0; k < 4 && op_ready !== 1'h1; k++) @(negedge clk);
    if (k == 4)
    begin
      error_cnt++;
      close_out();
    end
    @(negedge clk);
    op_valid = 1'h0;
    chk("acc", acc_q, ea);
    chk("flags", {2'h0, flags_q}, ef);
    chk("skip", {7'h00, skip_q}, sk);
    @(negedge clk);
    chk("dummy", {7'h00, dummy_cycle_q}, sk);
    chk("mem", mem_rdata, em);
  endtask : run
  task automatic t_rotate();
    run(RSD_OP_ROTATE_RIGHT_THROUGH_CARRY_TO_ACC, 8'h81, 8'h00, 8'h40, 8'h01,
      8'h81, 8'h00);
    run(RSD_OP_ROTATE_RIGHT_THROUGH_CARRY_TO_ACC, 8'h02, 8'h00, 8'h81, 8'h00,
      8'h02, 8'h00);
  endtask : t_rotate
  task automatic t_subtract();
    run(RSD_OP_SUBTRACT_WITH_BORROW_ACC, 8'h01, 8'h00, 8'h7f, 8'h19, 8'h01,
      8'h00);
    run(RSD_OP_SUBTRACT_WITH_BORROW_IMM, 8'h00, 8'hff, 8'h80, 8'h0a, 8'h00,
      8'h00);
    run(RSD_OP_SUBTRACT_WITH_BORROW_TO_MEM, 8'h80, 8'h00, 8'h80, 8'h10,
      8'hff, 8'h00);
  endtask : t_subtract
  task automatic t_decrement();
    run(RSD_OP_DECREMENT_COPY_SKIP_IF_ZERO, 8'h01, 8'h00, 8'h00, 8'h10,
      8'h01, 8'h01);
    run(RSD_OP_DECREMENT_SKIP_IF_ZERO, 8'h01, 8'h00, 8'h00, 8'h10, 8'h00,
      8'h01);
    run(RSD_OP_DECREMENT_SKIP_IF_ZERO, 8'h05, 8'h00, 8'h00, 8'h10, 8'h04,
      8'h00);
  endtask : t_decrement
  task automatic t_refuse();
    @(negedge clk);
    ld = 1'h1;
    ld_val = 8'h01;
    @(negedge clk);
    ld = 1'h0;
    op_valid = 1'h1;
    op_sel = RSD_OP_DECREMENT_SKIP_IF_ZERO;
    @(negedge clk);
    op_sel = RSD_OP_ROTATE_RIGHT_THROUGH_CARRY_TO_ACC;
    @(negedge clk);
    op_sel = RSD_OP_SUBTRACT_WITH_BORROW_IMM;
    imm_data = 8'h00;
    chk("ready", {7'h00, op_ready}, 8'h00);
    @(negedge clk);
    op_valid = 1'h0;
    chk("flags_refused", {2'h0, flags_q}, 8'h11);
    chk("acc_refused", acc_q, 8'h00);
  endtask : t_refuse
  initial
  begin
    repeat (2) @(negedge clk);
    reset = 1'h0;
    chk("acc_rst", acc_q, RSD_ACC_RST);
    t_rotate();
    t_subtract();
    t_decrement();
    t_refuse();
    close_out();
  end
endmodule : tb
`default_nettype wire
